// >>> rtl/cimt_top.sv
// Purpose: Interrupt mask registers and battery threshold control register
// Assumes: Host interface delivers one-cycle byte read and write strobes
// Notes:   Interrupt pin is active low and registered
`timescale 1ns/1ps
`default_nettype none
module cimt_top
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_hit_out,
  input  wire logic [7:0]  event_flags_a_in,
  input  wire logic [7:0]  event_flags_b_in,
  input  wire logic        continuous_timer_bit_in,
  input  wire logic        charge_timer_expired_in,
  output logic             irq_n_out,
  output logic [2:0]       good_batt_threshold_out,
  output logic [2:0]       fast_charge_entry_threshold_out,
  output logic [11:0]      good_batt_mv_out,
  output logic [11:0]      fast_charge_mv_out
);
  import cimt_pkg::*;

  logic [7:0] mask_a_reg;
  logic [7:0] mask_b_reg;
  logic [7:0] thresh_reg;
  logic [7:0] mask_b_eff;
  logic       req_a;
  logic       req_b;
  logic       wr_a;
  logic       wr_b;
  logic       wr_t;
  logic       timer_clr;

  // Named views of the mask fields
  logic       mask_low_batt_current;
  logic       mask_recharge;
  logic       mask_boost_overvolt;
  logic       mask_boost_thermal_sd;
  logic       mask_boost_fail;
  logic       mask_batt_undervolt;
  logic       mask_batt_low_level;
  logic       mask_topoff_done;
  logic       mask_input_overvolt;
  logic       mask_shorted_batt;
  logic       mask_die_temp;
  logic       mask_batt_temp;
  logic       mask_otg_overcurrent;
  logic       mask_batt_overcurrent;
  logic       mask_timer_expiry;

  // Named views of the latched event flags
  logic       low_batt_current_flag;
  logic       recharge_flag;
  logic       boost_overvolt_flag;
  logic       boost_thermal_sd_flag;
  logic       boost_fail_flag;
  logic       batt_undervolt_flag;
  logic       batt_low_level_flag;
  logic       topoff_done_flag;
  logic       input_overvolt_flag;
  logic       shorted_batt_flag;
  logic       die_temp_flag;
  logic       batt_temp_flag;
  logic       otg_overcurrent_flag;
  logic       batt_overcurrent_flag;
  logic       timer_expiry_flag;
  logic [7:0] flags_a_vec;
  logic [7:0] flags_b_vec;

  assign mask_low_batt_current = mask_a_reg[7];
  assign mask_recharge         = mask_a_reg[6];
  assign mask_boost_overvolt   = mask_a_reg[5];
  assign mask_boost_thermal_sd = mask_a_reg[4];
  assign mask_boost_fail       = mask_a_reg[3];
  assign mask_batt_undervolt   = mask_a_reg[2];
  assign mask_batt_low_level   = mask_a_reg[0];
  assign mask_topoff_done      = mask_b_reg[7];
  assign mask_input_overvolt   = mask_b_reg[6];
  assign mask_shorted_batt     = mask_b_reg[5];
  assign mask_die_temp         = mask_b_reg[4];
  assign mask_batt_temp        = mask_b_reg[3];
  assign mask_otg_overcurrent  = mask_b_reg[2];
  assign mask_batt_overcurrent = mask_b_reg[1];
  assign mask_timer_expiry     = mask_b_reg[0];

  assign low_batt_current_flag = event_flags_a_in[7];
  assign recharge_flag         = event_flags_a_in[6];
  assign boost_overvolt_flag   = event_flags_a_in[5];
  assign boost_thermal_sd_flag = event_flags_a_in[4];
  assign boost_fail_flag       = event_flags_a_in[3];
  assign batt_undervolt_flag   = event_flags_a_in[2];
  assign batt_low_level_flag   = event_flags_a_in[0];
  assign topoff_done_flag      = event_flags_b_in[7];
  assign input_overvolt_flag   = event_flags_b_in[6];
  assign shorted_batt_flag     = event_flags_b_in[5];
  assign die_temp_flag         = event_flags_b_in[4];
  assign batt_temp_flag        = event_flags_b_in[3];
  assign otg_overcurrent_flag  = event_flags_b_in[2];
  assign batt_overcurrent_flag = event_flags_b_in[1];
  assign timer_expiry_flag     = event_flags_b_in[0];

  // Bit 1 has no event of its own and no mask; passed through as is
  assign flags_a_vec = {low_batt_current_flag, recharge_flag, boost_overvolt_flag,
                        boost_thermal_sd_flag, boost_fail_flag, batt_undervolt_flag,
                        event_flags_a_in[1], batt_low_level_flag};
  assign flags_b_vec = {topoff_done_flag, input_overvolt_flag, shorted_batt_flag,
                        die_temp_flag, batt_temp_flag, otg_overcurrent_flag,
                        batt_overcurrent_flag, timer_expiry_flag};

  assign wr_a = reg_wr_in && (reg_addr_in == CIMT_OFS_MASK_A);
  assign wr_b = reg_wr_in && (reg_addr_in == CIMT_OFS_MASK_B);
  assign wr_t = reg_wr_in && (reg_addr_in == CIMT_OFS_THRESH);
  assign timer_clr = !continuous_timer_bit_in && charge_timer_expired_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      mask_a_reg <= CIMT_RST_MASK_A;
    else if (wr_a)
      mask_a_reg <= reg_wdata_in & CIMT_WMASK_MASK_A;
  end

  // Hardware clear wins over a simultaneous host write of the timer bit
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      mask_b_reg <= CIMT_RST_MASK_B;
    else
    begin
      if (wr_b)
        mask_b_reg <= reg_wdata_in & CIMT_WMASK_MASK_B;
      if (timer_clr)
        mask_b_reg[CIMT_TIMER_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      thresh_reg <= CIMT_RST_THRESH;
    else if (wr_t)
      thresh_reg <= reg_wdata_in & CIMT_WMASK_THRESH;
  end

  always_comb
  begin
    mask_b_eff = mask_b_reg;
    mask_b_eff[CIMT_TIMER_BIT] = mask_b_reg[CIMT_TIMER_BIT] && continuous_timer_bit_in;
  end

  cimt_irq_gate #(.W(8)) u_gate_a (
    .flags_in (flags_a_vec),
    .masks_in (mask_a_reg),
    .req_out  (req_a)
  );

  cimt_irq_gate #(.W(8)) u_gate_b (
    .flags_in (flags_b_vec),
    .masks_in (mask_b_eff),
    .req_out  (req_b)
  );

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      irq_n_out <= 1'b1;
    else
      irq_n_out <= !(req_a || req_b);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_hit_out   <= 1'b0;
    end
    else if (reg_rd_in)
    begin
      reg_hit_out <= 1'b1;
      unique case (reg_addr_in)
        CIMT_OFS_MASK_A:
          reg_rdata_out <= {mask_low_batt_current, mask_recharge, mask_boost_overvolt,
                            mask_boost_thermal_sd, mask_boost_fail, mask_batt_undervolt,
                            1'b0, mask_batt_low_level};
        CIMT_OFS_MASK_B:
          reg_rdata_out <= {mask_topoff_done, mask_input_overvolt, mask_shorted_batt,
                            mask_die_temp, mask_batt_temp, mask_otg_overcurrent,
                            mask_batt_overcurrent, mask_timer_expiry};
        CIMT_OFS_THRESH: reg_rdata_out <= thresh_reg;
        default:
        begin
          reg_rdata_out <= 8'h00;
          reg_hit_out   <= 1'b0;
        end
      endcase
    end
    else
      reg_hit_out <= 1'b0;
  end

  assign good_batt_threshold_out         = thresh_reg[CIMT_GOOD_LSB +: 3];
  assign fast_charge_entry_threshold_out = thresh_reg[CIMT_FAST_LSB +: 3];
  assign good_batt_mv_out = 12'(CIMT_GOOD_BASE_MV
                              + CIMT_STEP_MV * int'(thresh_reg[CIMT_GOOD_LSB +: 3]));
  assign fast_charge_mv_out = 12'(CIMT_FAST_BASE_MV
                                + CIMT_STEP_MV * int'(thresh_reg[CIMT_FAST_LSB +: 3]));
endmodule
`default_nettype wire

// >>> rtl/cimt_pkg.sv
// Purpose: Constants for the charger mask and battery threshold registers
// Assumes: Byte-wide register port from the serial host interface
// Notes:   Offsets are the printed register addresses
package cimt_pkg;
  localparam logic [7:0] CIMT_OFS_MASK_A      = 8'h09;
  localparam logic [7:0] CIMT_OFS_MASK_B      = 8'h0A;
  localparam logic [7:0] CIMT_OFS_THRESH      = 8'h0C;
  localparam logic [7:0] CIMT_RST_MASK_A      = 8'h00;
  localparam logic [7:0] CIMT_RST_MASK_B      = 8'h00;
  localparam logic [7:0] CIMT_RST_THRESH      = 8'h3F;
  localparam logic [7:0] CIMT_WMASK_MASK_A    = 8'hFD;
  localparam logic [7:0] CIMT_WMASK_MASK_B    = 8'hFF;
  localparam logic [7:0] CIMT_WMASK_THRESH    = 8'h3F;
  localparam int         CIMT_GOOD_LSB        = 3;
  localparam int         CIMT_FAST_LSB        = 0;
  localparam int         CIMT_TIMER_BIT       = 0;
  // Threshold codes in millivolts: base plus 100 mV per step
  localparam int         CIMT_GOOD_BASE_MV    = 3000;
  localparam int         CIMT_FAST_BASE_MV    = 2700;
  localparam int         CIMT_STEP_MV         = 100;
endpackage

// >>> rtl/cimt_irq_gate.sv
// Purpose: Gate latched event flags with mask bits onto an interrupt request
// Assumes: Flags and masks are synchronous to the system clock
// Notes:   Any unmasked set flag asserts the request
`timescale 1ns/1ps
`default_nettype none
module cimt_irq_gate #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] flags_in,
  input  wire logic [W-1:0] masks_in,
  output logic              req_out
);
  assign req_out = |(flags_in & ~masks_in);
endmodule
`default_nettype wire

// >>> verif/cimt_sva.sv
// Purpose: Port assertions for cimt_top
// Assumes: One clock, sync reset
// Notes: Bound to every cimt_top
`timescale 1ns/1ps
`default_nettype none
module cimt_sva import cimt_pkg::*; (
  input wire logic clk_sys_in, rst_in, reg_wr_in, reg_rd_in, reg_hit_out, irq_n_out,
  input wire logic continuous_timer_bit_in, charge_timer_expired_in,
  input wire logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out,
  input wire logic [7:0] event_flags_a_in, event_flags_b_in,
  input wire logic [2:0] good_batt_threshold_out, fast_charge_entry_threshold_out,
  input wire logic [11:0] good_batt_mv_out, fast_charge_mv_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  sequence tmr_clr_s;
    charge_timer_expired_in && !continuous_timer_bit_in ##1 reg_rd_in && reg_addr_in == 8'h0A;
  endsequence
  sequence wr_rd_s;
    reg_wr_in && reg_addr_in == 8'h0C ##1 !reg_wr_in ##1 reg_rd_in && reg_addr_in == 8'h0C;
  endsequence
  mask_rsv_a: assert property (reg_rd_in && reg_addr_in == 8'h09 |=> reg_hit_out && !reg_rdata_out[1])
    else $error("mask reserved bit set");
  thresh_rsv_a: assert property (reg_rd_in && reg_addr_in == 8'h0C |=> reg_rdata_out[7:6] == 2'h0)
    else $error("threshold reserved bits set");
  good_mv_a: assert property (good_batt_mv_out == 12'(CIMT_GOOD_BASE_MV + CIMT_STEP_MV * good_batt_threshold_out))
    else $error("good level wrong");
  fast_mv_a: assert property (fast_charge_mv_out == 12'(CIMT_FAST_BASE_MV + CIMT_STEP_MV * fast_charge_entry_threshold_out))
    else $error("fast level wrong");
  irq_idle_a: assert property (event_flags_a_in == 8'h00 && event_flags_b_in == 8'h00 |=> irq_n_out)
    else $error("irq without flag");
  timer_unmask_a: assert property (event_flags_b_in[0] && !continuous_timer_bit_in |=> !irq_n_out)
    else $error("timer flag masked");
  timer_clear_a: assert property (tmr_clr_s |=> !reg_rdata_out[0])
    else $error("timer mask not cleared");
  thresh_store_a: assert property (wr_rd_s |=> reg_rdata_out == ($past(reg_wdata_in, 3) & 8'h3F))
    else $error("threshold readback wrong");
endmodule
bind cimt_top cimt_sva i_sva (.*);
`default_nettype wire

// >>> verif/cimt_host.sv
// Purpose: Host model driving the register strobes
// Assumes: One transfer at a time
// Notes: Address inverted when idle
`timescale 1ns/1ps
`default_nettype none
module cimt_host (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] rdata_in,
  output logic [7:0]      addr_out, wdata_out,
  output logic            wr_out, rd_out
);
  initial {addr_out, wdata_out, wr_out, rd_out} = 18'h0;
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clk_sys_in) #1;
    {wr_out, rd_out, addr_out, wdata_out} = {w, !w, a, d};
    @(posedge clk_sys_in) #1;
    {wr_out, rd_out, addr_out} = {2'h0, ~a};
    q = rdata_in;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_cimt_top.sv
// Purpose: Random and corner tests of cimt_top
// Assumes: Host model issues single bytes
// Notes: Irq checked with settled flags
`timescale 1ns/1ps
`default_nettype none
module tb_cimt_top;
  import cimt_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, continuous_timer_bit = 1, tmr = 0, wr, rd, irq_n;
  logic [7:0] addr, wd, rdat, q, fa = 8'h00, fb = 8'h00;
  logic [7:0] m [16];
  logic [11:0] gmv, fmv;
  logic hit;
  logic [2:0] gth, fth;
  int n_errors = 0, cmp_count = 0, cyc = 0, seed = 79273;
  cimt_host i_cimt_host (.clk_sys_in, .rdata_in(rdat), .addr_out(addr), .wdata_out(wd), .wr_out(wr), .rd_out(rd));
  cimt_top i_cimt_top (.clk_sys_in, .rst_in, .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdat), .reg_hit_out(hit), .event_flags_a_in(fa), .event_flags_b_in(fb),
    .continuous_timer_bit_in(continuous_timer_bit), .charge_timer_expired_in(tmr), .irq_n_out(irq_n),
    .good_batt_threshold_out(gth), .fast_charge_entry_threshold_out(fth), .good_batt_mv_out(gmv),
    .fast_charge_mv_out(fmv));
  initial forever #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (++cyc > 5000) begin n_errors++; conclude(); end
  function automatic logic [7:0] wmask(input logic [7:0] a);
    return a == 8'h09 ? CIMT_WMASK_MASK_A : a == 8'h0A ? CIMT_WMASK_MASK_B : a == 8'h0C ? CIMT_WMASK_THRESH : 8'h00;
  endfunction
  function automatic logic exp_irq();
    return ~|((fa & ~m[9]) | (fb & ~(m[10] & {7'h7F, continuous_timer_bit})));
  endfunction
  task automatic chk(string n, logic [11:0] e, logic [11:0] s);
    cmp_count++;
    if (s !== e) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, s); end
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    m = '{default: 8'h00};
    m[12] = 8'h3F;
    repeat (20) @(posedge clk_sys_in);
    #1 rst_in = 0;
    for (int a = 9; a <= 12; a++)
    begin
      i_cimt_host.xfer(0, a[7:0], 8'h00, q);
      chk("reset", m[a], q);
      chk("reset hit", 12'(a != 11), hit);
    end
    for (int i = 0; i < 40; i++)
    begin
      logic [7:0] a, d;
      a = 8'h09 + 8'($random(seed) & 3);
      d = 8'($random(seed));
      i_cimt_host.xfer(1, a, d, q);
      m[a] = d & wmask(a);
      i_cimt_host.xfer(0, a, 8'h00, q);
      chk("readback", m[a], q);
      chk("hit", 12'(a != 8'h0B), hit);
      fa = 8'($random(seed)) & 8'hFD;
      fb = 8'($random(seed));
      repeat (3) @(posedge clk_sys_in);
      chk("irq", exp_irq(), irq_n);
      chk("good mv", 12'(CIMT_GOOD_BASE_MV + CIMT_STEP_MV * m[12][5:3]), gmv);
      chk("fast mv", 12'(CIMT_FAST_BASE_MV + CIMT_STEP_MV * m[12][2:0]), fmv);
      chk("good code", m[12][5:3], gth);
      chk("fast code", m[12][2:0], fth);
    end
    #1;
    i_cimt_host.xfer(1, 8'h0C, 8'hFF, q);
    m[12] = 8'h3F;
    chk("fast code top", m[12][2:0], fth);
    continuous_timer_bit = 0;
    i_cimt_host.xfer(1, 8'h0A, 8'h01, q);
    {m[10], fa, fb} = {8'h01, 8'h00, 8'h01};
    repeat (3) @(posedge clk_sys_in);
    chk("timer irq", 0, irq_n);
    #1 tmr = 1;
    fork #8 tmr = 0; join_none
    i_cimt_host.xfer(0, 8'h0A, 8'h00, q);
    chk("timer clear", 0, q[0]);
    conclude();
  end
endmodule
`default_nettype wire
